// [hdl/fpfc_pkg.sv]
// shared constants and types for the floating-point format converter
package fpfc_pkg;
    // field widths
    localparam int FPFC_EXP_W = 8;
    localparam int FPFC_SHORT_EXP_W = 4;
    localparam int FPFC_SHORT_MAN_W = 12;
    localparam int FPFC_SINGLE_MAN_W = 24;
    localparam int FPFC_EXT_MAN_W = 32;
    localparam int FPFC_SHORT_W = 16;
    localparam int FPFC_WORD_W = 32;
    localparam int FPFC_EXT_W = 40;
    // zero-fill counts for widening
    localparam int FPFC_SH2SG_FILL = 12;
    localparam int FPFC_SH2EX_FILL = 20;
    localparam int FPFC_SG2EX_FILL = 8;
    // native single word field positions
    localparam int FPFC_SG_EXP_HI = 31;
    localparam int FPFC_SG_EXP_LO = 24;
    localparam int FPFC_SG_SIGN = 23;
    localparam int FPFC_SG_FRAC_HI = 22;
    // short word field positions
    localparam int FPFC_SH_EXP_HI = 15;
    localparam int FPFC_SH_EXP_LO = 12;
    localparam int FPFC_SH_SIGN = 11;
    // extended word field positions
    localparam int FPFC_EX_EXP_HI = 39;
    localparam int FPFC_EX_EXP_LO = 32;
    localparam int FPFC_EX_SIGN = 31;
    // reserved zero exponents
    localparam logic [7:0] FPFC_ZERO_EXP = 8'h80;
    localparam logic [3:0] FPFC_SHORT_ZERO_EXP = 4'h8;
    // ieee fields
    localparam logic [7:0] FPFC_IEEE_EXP_MAX = 8'hFF;
    localparam logic [7:0] FPFC_IEEE_BIAS = 8'h7F;
    localparam logic [8:0] FPFC_IEEE_DENORM_EXP = 9'h182; // -126
    localparam logic [40:0] FPFC_EXT_ZERO = {1'b0, 8'h80, 32'h00000000};
    // source and target format selects
    typedef enum logic [2:0] {
        FPFC_FMT_SHORT = 3'b001,
        FPFC_FMT_SINGLE = 3'b010,
        FPFC_FMT_EXT = 3'b100
    } fpfc_fmt_t;
    // ieee class, one-hot
    typedef enum logic [4:0] {
        FPFC_CLS_ZERO = 5'b00001,
        FPFC_CLS_DENORM = 5'b00010,
        FPFC_CLS_NORM = 5'b00100,
        FPFC_CLS_INF = 5'b01000,
        FPFC_CLS_NAN = 5'b10000
    } fpfc_cls_t;
endpackage : fpfc_pkg

// [hdl/fpfc_ieee_class.sv]
// ieee single field splitter and classifier
`timescale 1ns/1ps
module fpfc_ieee_class
    import fpfc_pkg::*;
(
    // input word
    input wire logic [31:0] ieee_word,
    // decoded fields
    output logic ieee_sign,
    output logic [7:0] ieee_exp,
    output logic [22:0] ieee_frac,
    output logic [8:0] ieee_unbiased_exp,
    output logic [23:0] ieee_magnitude,
    output fpfc_cls_t ieee_class
);
    // sign on top, then biased exponent, then magnitude fraction
    assign ieee_sign = ieee_word[31];
    assign ieee_exp = ieee_word[30:23];
    assign ieee_frac = ieee_word[22:0];

    // exponent taken unsigned; denormals use fixed -126 and no hidden one
    always_comb begin
        if (ieee_exp == 8'h00) begin
            ieee_unbiased_exp = FPFC_IEEE_DENORM_EXP;
            ieee_magnitude = {1'b0, ieee_frac};
        end else begin
            ieee_unbiased_exp = {1'b0, ieee_exp} - {1'b0, FPFC_IEEE_BIAS};
            ieee_magnitude = {1'b1, ieee_frac};
        end
    end

    // classification by unsigned exponent and fraction
    always_comb begin
        if (ieee_exp == FPFC_IEEE_EXP_MAX) begin
            ieee_class = (ieee_frac != 23'h000000) ? FPFC_CLS_NAN : FPFC_CLS_INF;
        end else if (ieee_exp == 8'h00) begin
            ieee_class = (ieee_frac != 23'h000000) ? FPFC_CLS_DENORM : FPFC_CLS_ZERO;
        end else begin
            ieee_class = FPFC_CLS_NORM;
        end
    end
endmodule : fpfc_ieee_class

// [hdl/fpfc_converter.sv]
// native format converter: decode, widen/narrow, encode, ieee classify
`timescale 1ns/1ps
module fpfc_converter
    import fpfc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // operand in
    input wire logic op_valid,
    input wire logic [39:0] op_word,
    input wire fpfc_fmt_t op_src_fmt,
    input wire fpfc_fmt_t op_dst_fmt,
    // converted result, registered
    output logic res_valid,
    output logic [39:0] res_word,
    output logic res_is_zero,
    output logic [7:0] res_exp,
    output logic res_sign,
    output logic [32:0] res_full_man,
    // ieee decode path
    input wire logic [31:0] ieee_word,
    output logic ieee_sign,
    output logic [8:0] ieee_unbiased_exp,
    output logic [23:0] ieee_magnitude,
    output fpfc_cls_t ieee_class
);
    // common internal form: extended exponent, sign, 31-bit fraction, zero flag
    logic [7:0] dec_exp;
    logic dec_sign;
    logic [30:0] dec_frac;
    logic dec_zero;
    logic [39:0] enc_word_d;
    logic [32:0] full_man_d;

    // explicit mantissa with implied nonsign bit left of the point
    function automatic logic [32:0] fpfc_full_man(input logic s, input logic [30:0] f);
        fpfc_full_man = {s, ~s, f};
    endfunction : fpfc_full_man

    // decode source into internal form, all combinational so no cycle is added
    always_comb begin
        dec_exp = FPFC_ZERO_EXP;
        dec_sign = 1'b0;
        dec_frac = 31'h00000000;
        dec_zero = 1'b1;
        case (op_src_fmt)
            FPFC_FMT_SHORT: begin
                // short: sign-extend exponent, fraction left justified
                dec_exp = {{4{op_word[FPFC_SH_EXP_HI]}},
                    op_word[FPFC_SH_EXP_HI:FPFC_SH_EXP_LO]};
                dec_sign = op_word[FPFC_SH_SIGN];
                dec_frac = {op_word[10:0], 20'h00000};
                dec_zero = (op_word[FPFC_SH_EXP_HI:FPFC_SH_EXP_LO]
                    == FPFC_SHORT_ZERO_EXP);
            end
            FPFC_FMT_SINGLE: begin
                dec_exp = op_word[FPFC_SG_EXP_HI:FPFC_SG_EXP_LO];
                dec_sign = op_word[FPFC_SG_SIGN];
                dec_frac = {op_word[FPFC_SG_FRAC_HI:0], 8'h00};
                dec_zero = (op_word[FPFC_SG_EXP_HI:FPFC_SG_EXP_LO] == FPFC_ZERO_EXP);
            end
            FPFC_FMT_EXT: begin
                dec_exp = op_word[FPFC_EX_EXP_HI:FPFC_EX_EXP_LO];
                dec_sign = op_word[FPFC_EX_SIGN];
                dec_frac = op_word[30:0];
                dec_zero = (op_word[FPFC_EX_EXP_HI:FPFC_EX_EXP_LO] == FPFC_ZERO_EXP);
            end
            default: begin
                dec_zero = 1'b1;
            end
        endcase
    end

    // encode into target; zero always maps to the reserved encoding
    always_comb begin
        enc_word_d = FPFC_EXT_ZERO[39:0];
        case (op_dst_fmt)
            FPFC_FMT_SHORT: begin
                // narrowing to short is not a documented path; low-bit truncation kept
                if (dec_zero) begin
                    enc_word_d = {24'h000000, FPFC_SHORT_ZERO_EXP, 12'h000};
                end else begin
                    enc_word_d = {24'h000000, dec_exp[3:0], dec_sign, dec_frac[30:20]};
                end
            end
            FPFC_FMT_SINGLE: begin
                if (dec_zero) begin
                    enc_word_d = {8'h00, FPFC_ZERO_EXP, 24'h000000};
                end else begin
                    // upper 23 fraction bits kept, 8 dropped without rounding
                    enc_word_d = {8'h00, dec_exp, dec_sign, dec_frac[30:8]};
                end
            end
            FPFC_FMT_EXT: begin
                if (dec_zero) begin
                    enc_word_d = {FPFC_ZERO_EXP, 32'h00000000};
                end else begin
                    enc_word_d = {dec_exp, dec_sign, dec_frac};
                end
            end
            default: begin
                enc_word_d = {FPFC_ZERO_EXP, 32'h00000000};
            end
        endcase
    end

    // explicit mantissa for the arithmetic path; zero gives all zeros
    always_comb begin
        full_man_d = dec_zero ? 33'h000000000 : fpfc_full_man(dec_sign, dec_frac);
    end

    // single register stage: the conversion shares the operation's own cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            res_valid <= 1'b0;
        end else begin
            res_valid <= op_valid;
        end
    end

    // result data, loaded with every valid operand
    always_ff @(posedge clk) begin
        if (srst) begin
            res_word <= {FPFC_ZERO_EXP, 32'h00000000};
            res_is_zero <= 1'b1;
            res_exp <= FPFC_ZERO_EXP;
            res_sign <= 1'b0;
            res_full_man <= 33'h000000000;
        end else if (op_valid) begin
            res_word <= enc_word_d;
            res_is_zero <= dec_zero;
            res_exp <= dec_zero ? FPFC_ZERO_EXP : dec_exp;
            res_sign <= dec_zero ? 1'b0 : dec_sign;
            res_full_man <= full_man_d;
        end
    end

    // ieee classifier
    fpfc_ieee_class u_ieee (
        .ieee_word(ieee_word),
        .ieee_sign(ieee_sign),
        .ieee_exp(),
        .ieee_frac(),
        .ieee_unbiased_exp(ieee_unbiased_exp),
        .ieee_magnitude(ieee_magnitude),
        .ieee_class(ieee_class)
    );

    // assertions: steps shared by the properties below
    sequence s_op_in;
        op_valid;
    endsequence

    sequence s_op_zero;
        op_valid && dec_zero;
    endsequence

    sequence s_op_live;
        op_valid && !dec_zero;
    endsequence

    sequence s_op_idle;
        !op_valid;
    endsequence

    // one register stage and no more: the result follows its operand directly
    AST_LATENCY: assert property (@(posedge clk) disable iff (srst)
        s_op_in |=> res_valid)
        else $error("result not one cycle after operand");
    AST_NO_OP: assert property (@(posedge clk) disable iff (srst)
        s_op_idle |=> !res_valid)
        else $error("result strobe without operand");

    // reserved zeros, whatever sign and fraction the source carried
    AST_EXT_ZERO: assert property (@(posedge clk) disable iff (srst)
        s_op_zero ##0 (op_dst_fmt == FPFC_FMT_EXT)
        |=> res_word == 40'h8000000000)
        else $error("extended zero not reserved encoding");
    AST_SG_ZERO: assert property (@(posedge clk) disable iff (srst)
        s_op_zero ##0 (op_dst_fmt == FPFC_FMT_SINGLE)
        |=> res_word == 40'h0080000000)
        else $error("single zero not reserved encoding");
    AST_SH_ZERO: assert property (@(posedge clk) disable iff (srst)
        s_op_zero ##0 (op_dst_fmt == FPFC_FMT_SHORT)
        |=> res_word == 40'h0000008000)
        else $error("short zero not reserved encoding");
    // detection itself seen in the operand's own cycle, zero side outputs in the cycle after
    AST_SH_ZERO_DEC: assert property (@(posedge clk) disable iff (srst)
        op_valid && op_src_fmt == FPFC_FMT_SHORT && op_word[15:12] == FPFC_SHORT_ZERO_EXP
        |-> dec_zero)
        else $error("short reserved zero not detected");
    AST_ZERO_FLAGS: assert property (@(posedge clk) disable iff (srst)
        s_op_zero |=> res_is_zero && res_exp == FPFC_ZERO_EXP && !res_sign
        && res_full_man == 33'h000000000)
        else $error("zero source left nonzero side outputs");

    // widening: exponent sign-extended, mantissa left justified, low bits zero
    AST_SH2SG: assert property (@(posedge clk) disable iff (srst)
        s_op_live ##0 (op_src_fmt == FPFC_FMT_SHORT && op_dst_fmt == FPFC_FMT_SINGLE)
        |=> res_word[11:0] == 12'h000
        && res_word[31:24] == {{4{$past(op_word[15])}}, $past(op_word[15:12])})
        else $error("short to single widening wrong");
    AST_SH2SG_MAN: assert property (@(posedge clk) disable iff (srst)
        s_op_live ##0 (op_src_fmt == FPFC_FMT_SHORT && op_dst_fmt == FPFC_FMT_SINGLE)
        |=> res_word[23:12] == $past(op_word[11:0]) && res_word[39:32] == 8'h00)
        else $error("short to single mantissa misplaced");
    AST_SH2EX: assert property (@(posedge clk) disable iff (srst)
        s_op_live ##0 (op_src_fmt == FPFC_FMT_SHORT && op_dst_fmt == FPFC_FMT_EXT)
        |=> res_word[19:0] == 20'h00000)
        else $error("short to extended low bits not zero");
    AST_SH2EX_FIELDS: assert property (@(posedge clk) disable iff (srst)
        s_op_live ##0 (op_src_fmt == FPFC_FMT_SHORT && op_dst_fmt == FPFC_FMT_EXT)
        |=> res_word[39:32] == {{4{$past(op_word[15])}}, $past(op_word[15:12])}
        && res_word[31:20] == $past(op_word[11:0]))
        else $error("short to extended fields misplaced");
    AST_SG2EX: assert property (@(posedge clk) disable iff (srst)
        s_op_live ##0 (op_src_fmt == FPFC_FMT_SINGLE && op_dst_fmt == FPFC_FMT_EXT)
        |=> res_word == {$past(op_word[31:0]), 8'h00})
        else $error("single to extended widening wrong");

    // narrowing to single and same-format passes keep exponent and sign untouched
    AST_EX2SG: assert property (@(posedge clk) disable iff (srst)
        s_op_live ##0 (op_src_fmt == FPFC_FMT_EXT && op_dst_fmt == FPFC_FMT_SINGLE)
        |=> res_word == {8'h00, $past(op_word[39:8])})
        else $error("extended to single narrowing wrong");
    AST_EX_PASS: assert property (@(posedge clk) disable iff (srst)
        s_op_live ##0 (op_src_fmt == FPFC_FMT_EXT && op_dst_fmt == FPFC_FMT_EXT)
        |=> res_word == $past(op_word))
        else $error("extended pass altered the word");
    AST_SG_PASS: assert property (@(posedge clk) disable iff (srst)
        s_op_live ##0 (op_src_fmt == FPFC_FMT_SINGLE && op_dst_fmt == FPFC_FMT_SINGLE)
        |=> res_word == {8'h00, $past(op_word[31:0])})
        else $error("single pass altered the word");

    // explicit mantissa: implied bit is the inverse of the sign, fraction below it
    AST_FULL_MAN: assert property (@(posedge clk) disable iff (srst)
        s_op_live |=> res_full_man[32] != res_full_man[31])
        else $error("implied bit not inverse of sign");
    AST_FULL_MAN_EXT: assert property (@(posedge clk) disable iff (srst)
        s_op_live ##0 (op_src_fmt == FPFC_FMT_EXT)
        |=> res_full_man == {$past(op_word[31]), ~$past(op_word[31]), $past(op_word[30:0])})
        else $error("explicit mantissa misplaced");
    AST_EXT_SIDE: assert property (@(posedge clk) disable iff (srst)
        s_op_live ##0 (op_src_fmt == FPFC_FMT_EXT)
        |=> res_exp == $past(op_word[39:32]) && res_sign == $past(op_word[31]) && !res_is_zero)
        else $error("extended exponent or sign misdecoded");
    AST_SG_SIDE: assert property (@(posedge clk) disable iff (srst)
        s_op_live ##0 (op_src_fmt == FPFC_FMT_SINGLE)
        |=> res_exp == $past(op_word[31:24]) && res_sign == $past(op_word[23]))
        else $error("single exponent or sign misdecoded");

    // ieee classifier is combinational, so it is checked in the same cycle
    AST_IEEE_NAN: assert property (@(posedge clk) disable iff (srst)
        ieee_word[30:23] == 8'hFF && ieee_word[22:0] != 23'h000000
        |-> ieee_class == FPFC_CLS_NAN)
        else $error("ieee NaN misclassified");
    AST_IEEE_INF: assert property (@(posedge clk) disable iff (srst)
        ieee_word[30:23] == 8'hFF && ieee_word[22:0] == 23'h000000
        |-> ieee_class == FPFC_CLS_INF)
        else $error("ieee infinity misclassified");
    AST_IEEE_DEN: assert property (@(posedge clk) disable iff (srst)
        ieee_word[30:23] == 8'h00 && ieee_word[22:0] != 23'h000000
        |-> ieee_class == FPFC_CLS_DENORM && ieee_magnitude[23] == 1'b0
        && ieee_unbiased_exp == FPFC_IEEE_DENORM_EXP)
        else $error("ieee denormal misclassified");
    AST_IEEE_ZERO: assert property (@(posedge clk) disable iff (srst)
        ieee_word[30:23] == 8'h00 && ieee_word[22:0] == 23'h000000
        |-> ieee_class == FPFC_CLS_ZERO)
        else $error("ieee zero misclassified");

    // normal range: hidden one restored, bias removed
    AST_IEEE_NORM: assert property (@(posedge clk) disable iff (srst)
        ieee_word[30:23] != 8'h00 && ieee_word[30:23] != 8'hFF
        |-> ieee_class == FPFC_CLS_NORM
        && ieee_unbiased_exp == {1'b0, ieee_word[30:23]} - 9'h07F)
        else $error("ieee normal misdecoded");
    AST_IEEE_FIELDS: assert property (@(posedge clk) disable iff (srst)
        ieee_word[30:23] != 8'h00
        |-> ieee_magnitude == {1'b1, ieee_word[22:0]} && ieee_sign == ieee_word[31])
        else $error("ieee fields misplaced");
endmodule : fpfc_converter

// [sim/fp_format_converter_tb_top.sv]
// self-checking testbench for the floating-point format converter
`timescale 1ns/1ps
module fp_format_converter_tb_top
    import fpfc_pkg::*;
;
    // clock, reset and operand side
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic op_valid = 1'b0;
    logic [39:0] op_word = 40'h0;
    fpfc_fmt_t op_src_fmt = FPFC_FMT_SHORT;
    fpfc_fmt_t op_dst_fmt = FPFC_FMT_SHORT;
    logic [31:0] ieee_word = 32'h0;
    // observed outputs
    logic res_valid, res_is_zero, res_sign, ieee_sign;
    logic [39:0] res_word;
    logic [7:0] res_exp;
    logic [32:0] res_full_man;
    logic [8:0] ieee_unbiased_exp;
    logic [23:0] ieee_magnitude;
    fpfc_cls_t ieee_class;
    int failures = 0;
    int check_count = 0;

    fpfc_converter i_dut (.clk(clk), .srst(srst), .op_valid(op_valid), .op_word(op_word),
        .op_src_fmt(op_src_fmt), .op_dst_fmt(op_dst_fmt), .res_valid(res_valid),
        .res_word(res_word), .res_is_zero(res_is_zero), .res_exp(res_exp),
        .res_sign(res_sign), .res_full_man(res_full_man), .ieee_word(ieee_word),
        .ieee_sign(ieee_sign), .ieee_unbiased_exp(ieee_unbiased_exp),
        .ieee_magnitude(ieee_magnitude), .ieee_class(ieee_class));

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    // case equality so an unknown never passes
    task automatic chk(input logic [40:0] seen, input logic [40:0] want);
        check_count++;
        if (seen !== want) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask : chk

    // one operand; op_valid stays high so calls run back to back
    task automatic conv(input logic [39:0] w, input fpfc_fmt_t s, input fpfc_fmt_t d);
        op_valid = 1'b1;
        op_word = w;
        op_src_fmt = s;
        op_dst_fmt = d;
        @(negedge clk);
        chk(res_valid, 1'b1);
    endtask : conv

    task automatic idle();
        op_valid = 1'b0;
        @(negedge clk);
        chk(res_valid, 1'b0);
    endtask : idle

    task automatic t_reset();
        repeat (20) @(negedge clk);
        chk(res_valid, 1'b0);
        chk(res_word, 40'h8000000000);
        chk(res_is_zero, 1'b1);
        chk(res_exp, 8'h80);
        chk(res_sign, 1'b0);
        chk(res_full_man, 33'h0);
        srst = 1'b0;
        @(negedge clk);
        $display("test reset done");
    endtask : t_reset

    // widening and narrowing, back to back, both exponent signs
    task automatic t_widen();
        logic [15:0] sw [2] = '{16'h5ABC, 16'hC123};
        logic [31:0] sg = 32'h81ABCDEF;
        logic [39:0] ex = 40'h7FD2345679;
        for (int i = 0; i < 2; i++) begin
            conv({24'h0, sw[i]}, FPFC_FMT_SHORT, FPFC_FMT_SINGLE);
            chk(res_word, {8'h00, {4{sw[i][15]}}, sw[i], 12'h000});
            chk(res_exp, {{4{sw[i][15]}}, sw[i][15:12]});
            conv({24'h0, sw[i]}, FPFC_FMT_SHORT, FPFC_FMT_EXT);
            chk(res_word, {{4{sw[i][15]}}, sw[i], 20'h00000});
        end
        conv({8'h00, sg}, FPFC_FMT_SINGLE, FPFC_FMT_EXT);
        chk(res_word, {sg, 8'h00});
        conv(ex, FPFC_FMT_EXT, FPFC_FMT_SINGLE);
        chk(res_word, {8'h00, ex[39:8]});
        chk(res_full_man, {ex[31], ~ex[31], ex[30:0]});
        chk(res_exp, ex[39:32]);
        chk(res_sign, ex[31]);
        chk(res_is_zero, 1'b0);
        idle();
        // result data hold while no operand arrives
        chk(res_word, {8'h00, ex[39:8]});
        $display("test widen done");
    endtask : t_widen

    // reserved zeros, including dirty sign and fraction bits
    task automatic t_zero();
        conv(40'h0000008000, FPFC_FMT_SHORT, FPFC_FMT_EXT);
        chk(res_word, 40'h8000000000);
        chk(res_is_zero, 1'b1);
        chk(res_full_man, 33'h0);
        conv(40'h0000008ABC, FPFC_FMT_SHORT, FPFC_FMT_SINGLE);
        chk(res_word, 40'h0080000000);
        conv(40'h0080123456, FPFC_FMT_SINGLE, FPFC_FMT_EXT);
        chk(res_word, 40'h8000000000);
        chk(res_exp, 8'h80);
        chk(res_sign, 1'b0);
        idle();
        $display("test zero done");
    endtask : t_zero

    // same-format passes and the narrowing into short
    task automatic t_same();
        logic [39:0] ex = 40'h7FD2345679;
        conv(ex, FPFC_FMT_EXT, FPFC_FMT_EXT);
        chk(res_word, ex);
        conv(40'h0081ABCDEF, FPFC_FMT_SINGLE, FPFC_FMT_SINGLE);
        chk(res_word, 40'h0081ABCDEF);
        chk(res_exp, 8'h81);
        chk(res_sign, 1'b1);
        conv(40'h0000005ABC, FPFC_FMT_SHORT, FPFC_FMT_SHORT);
        chk(res_word, 40'h0000005ABC);
        conv(ex, FPFC_FMT_EXT, FPFC_FMT_SHORT);
        chk(res_word, {24'h000000, ex[35:32], ex[31], ex[30:20]});
        conv(40'h80FFFFFFFF, FPFC_FMT_EXT, FPFC_FMT_SHORT);
        chk(res_word, 40'h0000008000);
        idle();
        $display("test same-format done");
    endtask : t_same

    // ieee classifier, every class and the exponent boundaries
    task automatic t_ieee();
        logic [31:0] iw [7] = '{32'h7FC00000, 32'hFF800000, 32'h3F800000, 32'h00800000,
            32'h7F7FFFFF, 32'h80000001, 32'h80000000};
        fpfc_cls_t ic [7] = '{FPFC_CLS_NAN, FPFC_CLS_INF, FPFC_CLS_NORM, FPFC_CLS_NORM,
            FPFC_CLS_NORM, FPFC_CLS_DENORM, FPFC_CLS_ZERO};
        logic [8:0] ie [6] = '{9'h080, 9'h080, 9'h000, 9'h182, 9'h07F, 9'h182};
        logic [23:0] im [7] = '{24'hC00000, 24'h800000, 24'h800000, 24'h800000,
            24'hFFFFFF, 24'h000001, 24'h000000};
        for (int i = 0; i < 7; i++) begin
            ieee_word = iw[i];
            #1;
            chk(ieee_class, ic[i]);
            chk(ieee_sign, iw[i][31]);
            chk(ieee_magnitude, im[i]);
            if (i < 6) begin
                chk(ieee_unbiased_exp, ie[i]);
            end
            @(negedge clk);
        end
        $display("test ieee done");
    endtask : t_ieee

    task automatic stop_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    // main sequence
    initial begin
        t_reset();
        t_widen();
        t_zero();
        t_same();
        t_ieee();
        stop_test();
    end

    // the tests need well under 100 cycles; cut a hang short
    initial begin
        #(2000 * 25);
        failures++;
        stop_test();
    end
endmodule : fp_format_converter_tb_top
